// File: hw/cycle_timed_alu_instruction_unit.v
// decode, timing and execution of the arithmetic and logic instruction subset
`timescale 1ns/1ps
`include "alu_unit_map.vh"
module cycle_timed_alu_instruction_unit (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // program memory
    output wire [15:0] code_addr,
    output wire code_rd,
    input wire [7:0] code_byte,
    // internal data ram, read is combinational
    output reg [7:0] dmem_addr,
    output wire dmem_we,
    output wire [7:0] dmem_wdata,
    input wire [7:0] dmem_rdata,
    // external data space and expansion ram
    output wire [15:0] xmem_addr,
    output wire xmem_re,
    output wire xmem_we,
    output wire [7:0] xmem_wdata,
    input wire [7:0] xmem_rdata,
    // flash byte write
    output wire [15:0] flash_addr,
    output wire [7:0] flash_wdata,
    output wire flash_we,
    input wire program_store_control,
    // serial debug port
    input wire dbg_sel_n,
    input wire dbg_clk,
    input wire dbg_din,
    output wire dbg_dout,
    // status
    output wire halted,
    output wire instr_done,
    output wire bad_opcode,
    output wire [7:0] acc,
    output wire [7:0] program_status_word,
    output wire [15:0] pc
);
localparam S_OP = 2'h0;
localparam S_EX = 2'h1;
localparam S_HALT = 2'h2;
reg [1:0] state_reg;
reg [3:0] cnt_reg;
reg [7:0] op_reg, b1_reg, ptr_reg, a_reg, b_reg, psw_reg, wat_addr_reg, fl_data_reg;
reg [15:0] pc_reg, dptr_reg, brk_addr_reg, fl_addr_reg;
reg step_reg, skip_reg, hpend_reg, brk_en_reg, wat_en_reg, dclk_q, dsel_q, fl_we_reg;
reg [`DBG_MSB:0] din_reg, dout_reg;
// ----------------------------------------
// decode and timing
// ----------------------------------------
wire in_op = (state_reg == S_OP);
wire [7:0] op = in_op ? code_byte : op_reg;
// cycle index within the instruction, one per clock
wire [3:0] k = in_op ? `CYC_ONE : cnt_reg;
wire [3:0] hi = op[7:4];
wire [3:0] lo = op[3:0];
wire cy = psw_reg[`PSW_CY];
wire lg = (hi == `GRP_ORL) | (hi == `GRP_ANL) | (hi == `GRP_XRL);
wire addsub = (hi == `GRP_ADD) | (hi == `GRP_ADDC) | (hi == `GRP_SUBB);
wire incdec = (hi == `GRP_INC) | (hi == `GRP_DEC);
wire lg_dir = lg & ((lo == `LO_DIR_A) | (lo == `LO_DIR_IMM));
wire regop = ((lg | addsub | incdec) & (lo >= `LO_IMM)) | lg_dir;
wire m_imm = (lo == `LO_IMM);
wire m_dir = (lo == `LO_DIR) | lg_dir;
wire m_ind = (lo[3:1] == `LO_IND_HI);
wire m_rn = lo[3];
wire dest_mem = (incdec & !m_imm) | lg_dir;
wire movx = (hi[3:1] == `MOVX_HI) & ((lo == `MOVX_DPTR_LO) | (lo[3:1] == `MOVX_RI_LO));
wire movx_rd = movx & !op[4];
wire movc = (op == `OP_MOVC_PC) | (op == `OP_MOVC_DPTR);
wire is_br = (op[7:6] == `BR_HI) & (lo == `BR_LO);
wire br_ok = op[5] ? ((a_reg == 8'h00) ^ op[4]) : (cy ^ op[4]);
wire to_flash = program_store_control;
// register, immediate, direct and indirect forms of the arithmetic groups
wire blk = (lg | addsub | incdec) & (lo >= `LO_IMM);
wire a_op = (op == `OP_NOP) | (op == `OP_RR) | (op == `OP_RRC) | (op == `OP_RL) | (op == `OP_RLC) | (op == `OP_SWAP)
            | (op == `OP_DA) | (op == `OP_CLR) | (op == `OP_CPL) | (op == `OP_INC_DPTR);
wire bad = !(blk | lg_dir | (op == `OP_MUL) | (op == `OP_DIV) | is_br | movx | movc | a_op);
wire len2 = (blk & m_imm & !incdec)
            | (blk & (lo == `LO_DIR))
            | (lg & (lo == `LO_DIR_A)) | is_br;
wire [1:0] len = len2 ? `LEN_2 : (lg & (lo == `LO_DIR_IMM)) ? `LEN_3 : `LEN_1;
// most opcodes take one cycle per byte
wire [3:0] cyc = (blk & m_ind) ? `CYC_IND :
                 (op == `OP_MUL) ? `CYC_MUL : (op == `OP_DIV) ? `CYC_DIV :
                 is_br ? `CYC_BR : (movx | movc) ? `CYC_XDATA : {2'b00, len};
wire brk_hit = in_op & brk_en_reg & !skip_reg & (pc_reg == brk_addr_reg);
wire stop_now = in_op & (hpend_reg | brk_hit);
wire active = (in_op & !stop_now) | (state_reg == S_EX);
wire last = (k == cyc) | (is_br & (k == `CYC_TWO) & !br_ok);
wire exec = active & last;
wire fetch = active & ({2'b00, len} >= k);
// ----------------------------------------
// operands and data memory
// ----------------------------------------
wire [1:0] rs = psw_reg[`PSW_RS1:`PSW_RS0];
wire [7:0] psw_full = {psw_reg[7:1], ^a_reg};
wire [7:0] dir_a = (len == `LEN_3) ? b1_reg : code_byte;
wire ri_fetch = (k == `CYC_ONE) & ((regop & m_ind) | (movx & op[1]));
wire sfr_acc = (dir_a == `SFR_ACC);
wire sfr_b = (dir_a == `SFR_B);
wire sfr_psw = (dir_a == `SFR_PSW);
wire sfr_dpl = (dir_a == `SFR_DPL);
wire sfr_dph = (dir_a == `SFR_DPH);
wire sfr_hit = m_dir & (sfr_acc | sfr_b | sfr_psw | sfr_dpl | sfr_dph);
always @* begin
    if ((k == `CYC_ONE) & regop & m_rn)
        dmem_addr = {3'h0, rs, lo[2:0]};
    else if (ri_fetch)
        dmem_addr = {3'h0, rs, 2'h0, lo[0]};
    else if (m_ind)
        dmem_addr = ptr_reg;
    else
        dmem_addr = dir_a;
end
wire [7:0] dir_rd = sfr_acc ? a_reg : sfr_b ? b_reg : sfr_psw ? psw_full :
                    sfr_dpl ? dptr_reg[7:0] : sfr_dph ? dptr_reg[15:8] : dmem_rdata;
wire [7:0] mval = m_dir ? dir_rd : dmem_rdata;
wire [7:0] x = dest_mem ? mval : a_reg;
wire [7:0] y = incdec ? 8'h01 : (lo == `LO_DIR_A) ? a_reg : m_imm | (lo == `LO_DIR_IMM) ? code_byte : mval;
wire cin = ((hi == `GRP_ADDC) | (hi == `GRP_SUBB)) & cy;
wire is_sub = (hi == `GRP_SUBB) | (hi == `GRP_DEC);
wire [8:0] add9 = {1'b0, x} + {1'b0, y} + {8'h00, cin};
wire [8:0] sub9 = {1'b0, x} - {1'b0, y} - {8'h00, cin};
wire [4:0] add5 = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
wire [4:0] sub5 = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
wire [7:0] res = (hi == `GRP_ORL) ? (x | y) : (hi == `GRP_ANL) ? (x & y) : (hi == `GRP_XRL) ? (x ^ y) :
                 is_sub ? sub9[7:0] : add9[7:0];
// flag rules follow the standard set; inc and dec leave flags alone
wire cy_n = is_sub ? sub9[8] : add9[8];
wire ac_n = is_sub ? sub5[4] : add5[4];
wire ov_n = is_sub ? ((x[7] != y[7]) & (res[7] != x[7])) : ((x[7] == y[7]) & (res[7] != x[7]));
wire [15:0] prod = a_reg * b_reg;
wire da_lo = (a_reg[3:0] > 4'h9) | psw_reg[`PSW_AC];
wire [8:0] da1 = {1'b0, a_reg} + (da_lo ? 9'h006 : 9'h000);
wire da_hi = (da1[7:4] > 4'h9) | da1[8] | cy;
wire [8:0] da2 = {1'b0, da1[7:0]} + (da_hi ? 9'h060 : 9'h000);
wire [15:0] xaddr = op[1] ? {8'h00, ptr_reg} : dptr_reg;
wire [15:0] movc_addr = {8'h00, a_reg} + (op[4] ? dptr_reg : pc_reg);
assign dmem_we = exec & regop & dest_mem & !sfr_hit;
assign dmem_wdata = res;
wire wat_hit = wat_en_reg & dmem_we & (dmem_addr == wat_addr_reg);
wire dbg_rise = dbg_clk & !dclk_q & !dbg_sel_n;
wire dbg_start = !dbg_sel_n & dsel_q;
wire dbg_end = dbg_sel_n & !dsel_q;
wire [3:0] dcmd = din_reg[`DBG_CMD];
wire halt_cmd = dbg_end & (dcmd == `DBG_HALT);
wire run_cmd = dbg_end & (dcmd == `DBG_RUN);
wire step_cmd = dbg_end & (dcmd == `DBG_STEP);
// flash programming is only safe while the core cannot fetch
wire fl_cmd = dbg_end & (dcmd == `DBG_FLASH) & halted;
// ----------------------------------------
// core registers
// ----------------------------------------
always @(posedge ref_clk) begin
    if (!rst_n) begin
        state_reg <= S_OP;
        cnt_reg <= `CYC_ONE;
        op_reg <= 8'h00;
        b1_reg <= 8'h00;
        ptr_reg <= 8'h00;
        pc_reg <= `RST_PC;
        a_reg <= 8'h00;
        b_reg <= 8'h00;
        psw_reg <= `RST_PSW;
        dptr_reg <= 16'h0000;
        step_reg <= 1'b0;
        skip_reg <= 1'b0;
        hpend_reg <= 1'b0;
    end else begin
        case (state_reg)
            S_HALT: begin
                if (run_cmd | step_cmd) begin
                    state_reg <= S_OP;
                    skip_reg <= 1'b1;
                    step_reg <= step_cmd;
                end
            end
            S_OP: begin
                if (stop_now)
                    state_reg <= S_HALT;
                else if (!exec) begin
                    state_reg <= S_EX;
                    cnt_reg <= `CYC_TWO;
                    op_reg <= code_byte;
                end
            end
            default: begin
                cnt_reg <= cnt_reg + 4'h1;
                if (exec)
                    state_reg <= S_OP;
            end
        endcase
        if (exec & (step_reg | wat_hit))
            state_reg <= S_HALT;
        if (exec) begin
            skip_reg <= 1'b0;
            step_reg <= 1'b0;
        end
        hpend_reg <= (halt_cmd & !halted) | (hpend_reg & !halted);
        if (active & (k == `CYC_TWO))
            b1_reg <= code_byte;
        if (active & ri_fetch)
            ptr_reg <= dmem_rdata;
        if (fetch)
            pc_reg <= pc_reg + 16'h0001;
        if (exec & is_br & br_ok)
            pc_reg <= pc_reg + {{8{b1_reg[7]}}, b1_reg};
        if (exec) begin
            if (regop & (!dest_mem | (sfr_hit & sfr_acc)))
                a_reg <= res;
            if (regop & dest_mem & sfr_hit) begin
                if (sfr_b)
                    b_reg <= res;
                else if (sfr_psw)
                    psw_reg <= res;
                else if (sfr_dpl)
                    dptr_reg[7:0] <= res;
                else if (sfr_dph)
                    dptr_reg[15:8] <= res;
            end
            if (regop & addsub) begin
                psw_reg[`PSW_CY] <= cy_n;
                psw_reg[`PSW_AC] <= ac_n;
                psw_reg[`PSW_OV] <= ov_n;
            end
            if (movx_rd)
                a_reg <= to_flash ? code_byte : xmem_rdata;
            if (movc)
                a_reg <= code_byte;
            case (op)
                `OP_MUL: begin
                    a_reg <= prod[7:0];
                    b_reg <= prod[15:8];
                    psw_reg[`PSW_CY] <= 1'b0;
                    psw_reg[`PSW_OV] <= |prod[15:8];
                end
                `OP_DIV: begin
                    // divide by zero leaves a and b untouched
                    a_reg <= (b_reg != 8'h00) ? a_reg / b_reg : a_reg;
                    b_reg <= (b_reg != 8'h00) ? a_reg % b_reg : b_reg;
                    psw_reg[`PSW_CY] <= 1'b0;
                    psw_reg[`PSW_OV] <= (b_reg == 8'h00);
                end
                `OP_DA: begin
                    a_reg <= da2[7:0];
                    psw_reg[`PSW_CY] <= cy | da1[8] | da2[8];
                end
                `OP_CLR: a_reg <= 8'h00;
                `OP_CPL: a_reg <= ~a_reg;
                `OP_RL: a_reg <= {a_reg[6:0], a_reg[7]};
                `OP_RLC: begin
                    a_reg <= {a_reg[6:0], cy};
                    psw_reg[`PSW_CY] <= a_reg[7];
                end
                `OP_RR: a_reg <= {a_reg[0], a_reg[7:1]};
                `OP_RRC: begin
                    a_reg <= {cy, a_reg[7:1]};
                    psw_reg[`PSW_CY] <= a_reg[0];
                end
                `OP_SWAP: a_reg <= {a_reg[3:0], a_reg[7:4]};
                `OP_INC_DPTR: dptr_reg <= dptr_reg + 16'h0001;
                default: ;
            endcase
        end
    end
end
// ----------------------------------------
// debug port and flash write
// ----------------------------------------
always @(posedge ref_clk) begin
    if (!rst_n) begin
        dclk_q <= 1'b0;
        dsel_q <= 1'b1;
        din_reg <= {`DBG_W{1'b0}};
        dout_reg <= {`DBG_W{1'b0}};
        brk_addr_reg <= 16'h0000;
        brk_en_reg <= 1'b0;
        wat_addr_reg <= 8'h00;
        wat_en_reg <= 1'b0;
        fl_we_reg <= 1'b0;
        fl_addr_reg <= 16'h0000;
        fl_data_reg <= 8'h00;
    end else begin
        dclk_q <= dbg_clk;
        dsel_q <= dbg_sel_n;
        if (dbg_rise)
            din_reg <= {din_reg[`DBG_MSB-1:0], dbg_din};
        if (dbg_start)
            dout_reg <= {halted, 3'h0, pc_reg, a_reg};
        else if (dbg_rise)
            dout_reg <= {dout_reg[`DBG_MSB-1:0], 1'b0};
        if (dbg_end & (dcmd == `DBG_BRK)) begin
            brk_addr_reg <= din_reg[`DBG_ADDR];
            brk_en_reg <= din_reg[0];
        end
        if (dbg_end & (dcmd == `DBG_WATCH)) begin
            wat_addr_reg <= din_reg[15:8];
            wat_en_reg <= din_reg[0];
        end
        // a write leaves one cycle after the accepting edge
        fl_we_reg <= fl_cmd | (exec & movx & !movx_rd & to_flash);
        if (fl_cmd) begin
            fl_addr_reg <= din_reg[`DBG_ADDR];
            fl_data_reg <= din_reg[`DBG_DATA];
        end else if (exec & movx) begin
            fl_addr_reg <= xaddr;
            fl_data_reg <= a_reg;
        end
    end
end
// ----------------------------------------
// outputs
// ----------------------------------------
assign code_addr = (exec & movc) ? movc_addr : (exec & movx_rd & to_flash) ? xaddr : pc_reg;
assign code_rd = fetch | (exec & (movc | (movx_rd & to_flash)));
assign xmem_addr = xaddr;
assign xmem_re = exec & movx_rd & !to_flash;
assign xmem_we = exec & movx & !movx_rd & !to_flash;
assign xmem_wdata = a_reg;
assign flash_addr = fl_addr_reg;
assign flash_wdata = fl_data_reg;
assign flash_we = fl_we_reg;
assign dbg_dout = dout_reg[`DBG_MSB];
assign halted = (state_reg == S_HALT);
assign instr_done = exec;
assign bad_opcode = exec & bad;
assign acc = a_reg;
assign program_status_word = psw_full;
assign pc = pc_reg;
endmodule // cycle_timed_alu_instruction_unit

// File: hw/alu_unit_map.vh
// constants for the cycle timed alu instruction unit
// Functional notes
// - timing counted in clock cycles only
// - cycles equal bytes for most instructions
// - untaken conditional branch one cycle shorter
// - standard opcodes, modes and flag effects
// - xdata move reaches flash when selected
// - xdata move reaches xram when deselected
// - byte flash access: code move reads, xdata writes
// - serial port programs flash, talks to debug
// - breakpoints, watchpoints, halt, run, single step
// - indirect operand: one byte, two cycles
// - add with carry register: one cycle
// - add with carry immediate: two cycles
// - subtract direct with borrow: two cycles
// - and immediate into direct: three cycles
// - xor accumulator into direct: two cycles
// - rotate left through carry: one cycle
// - no instruction over eight cycles
`ifndef ALU_UNIT_MAP_VH
`define ALU_UNIT_MAP_VH
// ----------------------------------------
// cycle and length figures
// ----------------------------------------
`define CYC_ONE 4'h1
`define CYC_TWO 4'h2
`define CYC_SAME 4'h0
`define CYC_IND 4'h2
`define CYC_XDATA 4'h3
`define CYC_BR 4'h3
`define CYC_MUL 4'h4
`define CYC_DIV 4'h8
`define LEN_1 2'h1
`define LEN_2 2'h2
`define LEN_3 2'h3
// ----------------------------------------
// opcode groups and fields
// ----------------------------------------
`define GRP_INC 4'h0
`define GRP_DEC 4'h1
`define GRP_ADD 4'h2
`define GRP_ADDC 4'h3
`define GRP_ORL 4'h4
`define GRP_ANL 4'h5
`define GRP_XRL 4'h6
`define GRP_SUBB 4'h9
`define LO_DIR_A 4'h2
`define LO_DIR_IMM 4'h3
`define LO_IMM 4'h4
`define LO_DIR 4'h5
`define LO_IND_HI 3'h3
`define OP_NOP 8'h00
`define OP_RR 8'h03
`define OP_RRC 8'h13
`define OP_RL 8'h23
`define OP_RLC 8'h33
`define OP_MOVC_PC 8'h83
`define OP_DIV 8'h84
`define OP_MOVC_DPTR 8'h93
`define OP_INC_DPTR 8'hA3
`define OP_MUL 8'hA4
`define OP_SWAP 8'hC4
`define OP_DA 8'hD4
`define OP_CLR 8'hE4
`define OP_CPL 8'hF4
`define MOVX_HI 3'h7
`define MOVX_DPTR_LO 4'h0
`define MOVX_RI_LO 3'h1
`define BR_HI 2'h1
`define BR_LO 4'h0
// ----------------------------------------
// special function addresses and flags
// ----------------------------------------
`define SFR_DPL 8'h82
`define SFR_DPH 8'h83
`define SFR_PSW 8'hD0
`define SFR_ACC 8'hE0
`define SFR_B 8'hF0
`define PSW_CY 7
`define PSW_AC 6
`define PSW_RS1 4
`define PSW_RS0 3
`define PSW_OV 2
`define RST_PSW 8'h00
`define RST_PC 16'h0000
// ----------------------------------------
// debug frame
// ----------------------------------------
`define DBG_W 28
`define DBG_MSB 27
`define DBG_CMD 27:24
`define DBG_ADDR 23:8
`define DBG_DATA 7:0
`define DBG_HALT 4'h1
`define DBG_RUN 4'h2
`define DBG_STEP 4'h3
`define DBG_BRK 4'h4
`define DBG_WATCH 4'h5
`define DBG_FLASH 4'h6
`endif

// File: verification/alu_unit_monitor.sv
// assertion checker on the ports of the cycle timed alu instruction unit
`timescale 1ns/1ps
module alu_unit_monitor (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // memories
    input wire [15:0] code_addr,
    input wire code_rd,
    input wire [7:0] dmem_addr,
    input wire dmem_we,
    input wire xmem_re,
    input wire xmem_we,
    input wire flash_we,
    input wire program_store_control,
    // status
    input wire halted,
    input wire instr_done,
    input wire bad_opcode,
    input wire [7:0] acc,
    input wire [7:0] program_status_word,
    input wire [15:0] pc
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // helper: cycles spent in one instruction
    // ----------------------------------------
    reg [3:0] stall_reg;
    always @(posedge ref_clk) begin
        if (!rst_n || instr_done || halted) begin
            stall_reg <= 4'h0;
        end else begin
            stall_reg <= stall_reg + 4'h1;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    max_eight_cycles_a: assert property (stall_reg < 4'h8)
        else $error("instruction ran past eight cycles");
    seq_fetch_a: assert property (code_rd && !instr_done ##1 code_rd |-> code_addr == $past(code_addr) + 16'h0001)
        else $error("operand byte not fetched from next address");
    halt_no_fetch_a: assert property (halted |-> !code_rd)
        else $error("fetch while halted");
    halt_pc_hold_a: assert property (halted && $past(halted) |-> $stable(pc))
        else $error("pc moved while halted");
    bad_with_done_a: assert property (bad_opcode |-> instr_done)
        else $error("bad opcode flag outside instruction end");
    acc_at_end_a: assert property (!instr_done |=> $stable(acc))
        else $error("accumulator changed before instruction end");
    parity_flag_a: assert property (program_status_word[0] == ^acc)
        else $error("parity flag wrong");
    sfr_not_ram_a: assert property (dmem_we |-> !(dmem_addr inside {8'hE0, 8'hF0, 8'hD0, 8'h82, 8'h83}))
        else $error("special register write leaked to ram");
    flash_after_movx_a: assert property (flash_we |-> halted || ($past(instr_done) && $past(program_store_control)))
        else $error("flash write without selected data move");
    flash_pulse_a: assert property (flash_we |=> !flash_we)
        else $error("flash write strobe longer than one cycle");
    xdata_space_a: assert property (xmem_re || xmem_we |-> !program_store_control && instr_done)
        else $error("external data strobe at wrong time or space");
    cover property (flash_we);
    cover property (xmem_we);
    cover property (bad_opcode);
    cover property ($rose(halted));
endmodule // alu_unit_monitor

bind cycle_timed_alu_instruction_unit alu_unit_monitor i_alu_unit_monitor (.ref_clk, .rst_n, .code_addr,
    .code_rd, .dmem_addr, .dmem_we, .xmem_re, .xmem_we, .flash_we, .program_store_control, .halted,
    .instr_done, .bad_opcode, .acc, .program_status_word, .pc);

// File: verification/mem_partner.sv
// program, internal and external memory model beside the instruction unit
`timescale 1ns/1ps
module mem_partner (
    // clock
    input wire ref_clk,
    // program memory and flash write
    input wire [15:0] code_addr,
    output wire [7:0] code_byte,
    input wire [15:0] flash_addr,
    input wire [7:0] flash_wdata,
    input wire flash_we,
    // internal ram
    input wire [7:0] dmem_addr,
    input wire dmem_we,
    input wire [7:0] dmem_wdata,
    output wire [7:0] dmem_rdata,
    // external ram
    input wire [15:0] xmem_addr,
    input wire xmem_re,
    input wire xmem_we,
    input wire [7:0] xmem_wdata,
    output wire [7:0] xmem_rdata
);
    reg [7:0] code [0:1023];
    reg [7:0] dram [0:255];
    reg [7:0] xram [0:255];
    reg [7:0] xlast = 8'h00;
    reg [15:0] f_addr = 16'h0000;
    reg [7:0] f_data = 8'h00;
    integer n_flash = 0;
    assign code_byte = code[code_addr[9:0]];
    assign dmem_rdata = dram[dmem_addr];
    // data bus is not held outside a read strobe
    assign xmem_rdata = xmem_re ? xram[xmem_addr[7:0]] : ~xlast;
    always @(posedge ref_clk) begin
        if (xmem_re) begin
            xlast <= xram[xmem_addr[7:0]];
        end
        if (xmem_we) begin
            xram[xmem_addr[7:0]] <= xmem_wdata;
        end
        if (dmem_we) begin
            dram[dmem_addr] <= dmem_wdata;
        end
        if (flash_we) begin
            code[flash_addr[9:0]] <= flash_wdata;
            f_addr <= flash_addr;
            f_data <= flash_wdata;
            n_flash <= n_flash + 1;
        end
    end
endmodule // mem_partner

// File: verification/cycle_timed_alu_instruction_unit_tb.sv
// self-checking testbench of the cycle timed alu instruction unit
`timescale 1ns/1ps
module cycle_timed_alu_instruction_unit_tb;
    reg ref_clk = 1'b0;
    reg rst_n = 1'b0;
    reg program_store_control = 1'b0;
    reg dbg_sel_n = 1'b1;
    reg dbg_clk = 1'b0;
    reg dbg_din = 1'b0;
    wire [15:0] code_addr, xmem_addr, flash_addr, pc;
    wire [7:0] code_byte, dmem_addr, dmem_wdata, dmem_rdata, xmem_wdata, xmem_rdata, flash_wdata, acc, program_status_word;
    wire code_rd, dmem_we, xmem_re, xmem_we, flash_we, dbg_dout, halted, instr_done, bad_opcode;
    integer n_mismatch = 0;
    integer n_compared = 0;
    integer k = 0;
    integer cnt = 0;
    integer i, w, pass, seed;
    reg run_on = 1'b0;
    reg [7:0] r1, r2, r3, r4, r5, r6, x, d31, d32;
    reg [15:0] p0;
    reg [271:0] img;
    // cycles per instruction in program order
    reg [87:0] exp_cyc = 88'h1213132212232133481313;
    always #2 ref_clk = ~ref_clk;
    cycle_timed_alu_instruction_unit i_cycle_timed_alu_instruction_unit (.ref_clk(ref_clk), .rst_n(rst_n),
        .code_addr(code_addr), .code_rd(code_rd), .code_byte(code_byte), .dmem_addr(dmem_addr),
        .dmem_we(dmem_we), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .xmem_addr(xmem_addr),
        .xmem_re(xmem_re), .xmem_we(xmem_we), .xmem_wdata(xmem_wdata), .xmem_rdata(xmem_rdata),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_we(flash_we),
        .program_store_control(program_store_control), .dbg_sel_n(dbg_sel_n), .dbg_clk(dbg_clk),
        .dbg_din(dbg_din), .dbg_dout(dbg_dout), .halted(halted), .instr_done(instr_done),
        .bad_opcode(bad_opcode), .acc(acc), .program_status_word(program_status_word), .pc(pc));
    mem_partner i_mem (.ref_clk(ref_clk), .code_addr(code_addr), .code_byte(code_byte),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_we(flash_we), .dmem_addr(dmem_addr),
        .dmem_we(dmem_we), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .xmem_addr(xmem_addr),
        .xmem_re(xmem_re), .xmem_we(xmem_we), .xmem_wdata(xmem_wdata), .xmem_rdata(xmem_rdata));
    // ----------------------------------------
    // compare, verdict and expectations
    // ----------------------------------------
    task check(input [8*12-1:0] what, input [15:0] exp_v, input [15:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp_v) begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR %0s expected %h seen %h", what, exp_v, got);
            end
        end
    endtask
    task print_verdict;
        begin
            if (n_mismatch == 0 && n_compared > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    // accumulator value reaching the data move, and the two ram results
    task predict;
        reg [8:0] s;
        reg [15:0] p;
        begin
            s = {1'b0, 8'hE4} + r1;
            s = {1'b0, s[7:0]} + r2 + s[8];
            s = {1'b0, s[7:0]} + 8'h40 + s[8];
            s = {1'b0, s[7:0]} + r3;
            s = {1'b0, s[7:0]} - r4 - s[8];
            d31 = r6 & r5;
            d32 = 8'h5A ^ s[7:0];
            s = {s[7:0], s[8]};
            p = s[7:0] * 8'h07;
            x = (p[15:8] == 8'h00) ? p[7:0] : p[7:0] / p[15:8];
        end
    endtask
    // one serial frame, command in the top nibble, first bit lands on top
    task frame(input [3:0] cmd);
        reg [27:0] sh;
        integer j;
        begin
            sh = {cmd, 24'h000000};
            dbg_sel_n = 1'b0;
            repeat (2) @(negedge ref_clk);
            check("dbg_dout", {15'h0, cmd == 4'h2}, {15'h0, dbg_dout});
            for (j = 27; j >= 0; j = j - 1) begin
                dbg_din = sh[j];
                dbg_clk = 1'b1;
                repeat (2) @(negedge ref_clk);
                dbg_clk = 1'b0;
                repeat (2) @(negedge ref_clk);
            end
            dbg_sel_n = 1'b1;
            repeat (4) @(negedge ref_clk);
        end
    endtask
    // ----------------------------------------
    // instruction length tracking
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (run_on && k < 22) begin
            cnt = cnt + 1;
            if (instr_done === 1'b1) begin
                check("cycles", exp_cyc[4*(21-k) +: 4], cnt[15:0]);
                check("bad_opcode", {15'h0, k == 18}, {15'h0, bad_opcode});
                k = k + 1;
                cnt = 0;
            end
        end
    end
    initial begin
        #(4 * 20000);
        n_mismatch = n_mismatch + 1;
        print_verdict;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = $urandom(32'h09D2);
        for (pass = 0; pass < 2; pass = pass + 1) begin
            rst_n = 1'b0;
            run_on = 1'b0;
            repeat (12) @(negedge ref_clk);
            r1 = $urandom;
            r2 = $urandom;
            r3 = $urandom;
            r4 = $urandom;
            r5 = $urandom;
            r6 = $urandom;
            predict;
            img = {8'hE4, 8'h70, 8'h00, 8'hF4, 8'h70, 8'h00, 8'hE4, 8'h93, 8'h24, r1, 8'h34, r2, 8'h38,
                   8'h26, 8'h95, 8'h30, 8'h53, 8'h31, r5, 8'h62, 8'h32, 8'h33, 8'h53, 8'hF0, 8'h00, 8'h43,
                   8'hF0, 8'h07, 8'hA4, 8'h84, 8'hA5, 8'hF0, 8'hE4, 8'hE0};
            for (i = 0; i < 1024; i = i + 1) begin
                i_mem.code[i] = (i < 34) ? img[8*(33-i) +: 8] : 8'h00;
                i_mem.dram[i % 256] = 8'h00;
                i_mem.xram[i % 256] = ~x;
            end
            i_mem.dram[0] = 8'h40;
            i_mem.dram[8'h40] = r3;
            i_mem.dram[8'h30] = r4;
            i_mem.dram[8'h31] = r6;
            i_mem.dram[8'h32] = 8'h5A;
            i_mem.n_flash = 0;
            program_store_control = pass[0];
            check("reset_state", 16'h0000, {acc, program_status_word | {7'h00, halted}});
            check("reset_pc", 16'h0000, pc);
            k = 0;
            cnt = 0;
            run_on = 1'b1;
            rst_n = 1'b1;
            for (w = 0; w < 200 && k < 22; w = w + 1) begin
                @(negedge ref_clk);
            end
            check("instr_count", 16'd22, k[15:0]);
            repeat (2) @(negedge ref_clk);
            check("acc", {8'h00, x}, {8'h00, acc});
            check("carry_par", {8'h00, 7'h00, ^x}, {8'h00, program_status_word[7], program_status_word[6:0] & 7'h01});
            check("and_direct", {8'h00, d31}, {8'h00, i_mem.dram[8'h31]});
            check("xor_direct", {8'h00, d32}, {8'h00, i_mem.dram[8'h32]});
            if (pass == 1) begin
                check("flash_log", {x, 8'h01}, {i_mem.f_data, i_mem.n_flash[7:0]});
                check("flash_addr", 16'h0000, i_mem.f_addr);
                check("xram_kept", {8'h00, ~x}, {8'h00, i_mem.xram[0]});
            end else begin
                check("xram_write", {8'h00, x}, {8'h00, i_mem.xram[0]});
                check("no_flash", 16'h0000, i_mem.n_flash[15:0]);
            end
            frame(4'h1);
            check("halt", 16'h0001, {15'h0, halted});
            p0 = pc;
            repeat (3) @(negedge ref_clk);
            check("halt_pc", p0, pc);
            check("halt_fetch", 16'h0000, {15'h0, code_rd});
            frame(4'h2);
            check("resume", 16'h0000, {15'h0, halted});
        end
        print_verdict;
    end
endmodule // cycle_timed_alu_instruction_unit_tb
